// ===== shared/ocfg_regs.svh
// register map constants for the output protection configuration bank
`ifndef OCFG_REGS_SVH
`define OCFG_REGS_SVH
`define OCFG_FRAME_BITS 16
`define OCFG_CNT_W 4
`define OCFG_SEL_W 2
`define OCFG_ADDR_W 3
`define OCFG_DATA_W 9
`define OCFG_FAULT_W 7
`define OCFG_OC_W 8
`define OCFG_ADDR_FAULT 3'h3
`define OCFG_ADDR_OC 3'h4
`define OCFG_ADDR_GLOB 3'h5
`define OCFG_ADDR_CAL 3'h7
// output_fault_config fields
`define OCFG_FLT_RETRY_UNL 6
`define OCFG_FLT_RETRY_DIS 5
`define OCFG_FLT_SHORT_DIS 4
`define OCFG_FLT_ONOL_DIS 3
`define OCFG_FLT_OFFOL_DIS 2
`define OCFG_FLT_ONOL_LED 1
`define OCFG_FLT_RATIO 0
// output_overcurrent_config fields
`define OCFG_OC_COOL_HI 7
`define OCFG_OC_COOL_LO 6
`define OCFG_OC_INR_HI 5
`define OCFG_OC_INR_LO 4
`define OCFG_OC_HIGH_OVR 3
`define OCFG_OC_STDY_HI 2
`define OCFG_OC_STDY_LO 1
`define OCFG_OC_MODE 0
// global_config fields
`define OCFG_GL_SUPPLY_EN 8
`define OCFG_GL_PWM_EN 7
`define OCFG_GL_CLK_SEL 6
`define OCFG_GL_TEMP_EN 5
`define OCFG_GL_CUR_EN 4
`define OCFG_GL_COPY_HI 3
`define OCFG_GL_COPY_LO 2
`define OCFG_GL_UNUSED 1
`define OCFG_GL_OVERVOLTAGE_PROTECT_DISABLE 0
`define OCFG_GL_MASK 9'h1fd
// reset values
`define OCFG_RST_FAULT 7'h00
`define OCFG_RST_OC 8'h00
`define OCFG_RST_GLOB 9'h000
`define OCFG_RST_CAL 9'h000
`define OCFG_CS_IDLE 1'h1
`endif

// ===== shared/ocfg_pkg.sv
// types shared by the output protection configuration bank
package ocfg_pkg;
	typedef enum logic [1:0] {
		ONOL_BULB = 2'h0,
		ONOL_LED = 2'h1,
		ONOL_OFF = 2'h2
	} ocfg_onol_e;
	typedef enum logic [1:0] {
		COOL_MEDIUM = 2'h0,
		COOL_SLOW = 2'h1,
		COOL_FAST = 2'h2
	} ocfg_cool_e;
	typedef enum logic [1:0] {
		INR_SLOW = 2'h0,
		INR_FAST = 2'h1,
		INR_MEDIUM = 2'h2,
		INR_VSLOW = 2'h3
	} ocfg_inrush_e;
	typedef enum logic [1:0] {
		STDY_TWO = 2'h0,
		STDY_THREE = 2'h1,
		STDY_FOUR = 2'h2,
		STDY_ONE = 2'h3
	} ocfg_steady_e;
	typedef enum logic [1:0] {
		FB_TRISTATE = 2'h0,
		FB_CURRENT = 2'h1,
		FB_TEMP = 2'h2
	} ocfg_fb_e;
	typedef enum logic [1:0] {
		PCLK_NONE = 2'h0,
		PCLK_EXT = 2'h1,
		PCLK_INT = 2'h2
	} ocfg_pclk_e;
	typedef struct packed {
		logic wd;
		logic [1:0] sel;
		logic [2:0] addr;
		logic unused;
		logic [8:0] data;
	} ocfg_frame_s;
	typedef struct packed {
		logic retry_unlimited;
		logic retry_disable;
		logic supply_short_protect_disable;
		ocfg_onol_e on_openload_mode;
		logic off_openload_disable;
		logic sense_ratio_high;
		ocfg_cool_e cooling;
		ocfg_inrush_e inrush;
		logic high_level_override;
		ocfg_steady_e steady;
		logic overcurrent_mode_select;
	} ocfg_chan_s;
	typedef struct packed {
		logic supply_fail_detect_en;
		logic pwm_enable;
		ocfg_pclk_e pwm_clock;
		ocfg_fb_e feedback_mode;
		logic [1:0] feedback_channel;
		logic overvoltage_protect_disable;
	} ocfg_glob_s;
endpackage

// ===== hdl/ocfg_spi_rx.sv
// serial link receiver on the link clock: shift register and gray bit pointer
`include "ocfg_regs.svh"
module ocfg_spi_rx
	import ocfg_pkg::*;
#(
	parameter int PTR_W = 8
) (
	input wire logic spi_sclk,
	input wire logic sys_rst,
	input wire logic spi_cs_n,
	input wire logic spi_si,
	output logic [`OCFG_FRAME_BITS-1:0] word,
	output logic [PTR_W-1:0] bit_ptr_gray
);
	logic [PTR_W-1:0] bit_cnt_r;
	logic [PTR_W-1:0] bit_cnt_nxt;
	logic [PTR_W-1:0] gray_r;
	logic [`OCFG_FRAME_BITS-1:0] shift_r;

	if (PTR_W <= `OCFG_CNT_W) begin : g_bad_ptr
		$error("PTR_W must exceed the frame count width");
	end

	assign bit_cnt_nxt = PTR_W'(bit_cnt_r + 1'b1);

	// link clock stands still outside frames; pointer and word stay frozen
	always_ff @(posedge spi_sclk or posedge sys_rst) begin
		if (sys_rst) begin
			bit_cnt_r <= '0;
			gray_r <= '0;
		end else if (!spi_cs_n) begin
			bit_cnt_r <= bit_cnt_nxt;
			gray_r <= bit_cnt_nxt ^ (bit_cnt_nxt >> 1);
		end
	end

	// last sixteen bits of the frame stay in the shifter
	always_ff @(posedge spi_sclk) begin
		if (!spi_cs_n) begin
			shift_r <= {shift_r[`OCFG_FRAME_BITS-2:0], spi_si};
		end
	end

	assign word = shift_r;
	assign bit_ptr_gray = gray_r;
endmodule

// ===== hdl/ocfg_top.sv
// output protection configuration register bank with its serial frame intake
`include "ocfg_regs.svh"
module ocfg_top
	import ocfg_pkg::*;
#(
	parameter int NCH = 4,
	parameter int PTR_W = 8
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic spi_sclk,
	input wire logic spi_cs_n,
	input wire logic spi_si,
	input wire logic supply_por,
	input wire logic logic_supply_low,
	output ocfg_chan_s [NCH-1:0] chan_cfg,
	output ocfg_glob_s glob_cfg,
	output logic outputs_from_pwm,
	output logic failsafe,
	output logic [`OCFG_DATA_W-1:0] osc_cal
);
	// ==========================================================
	// declarations
	logic [`OCFG_FRAME_BITS-1:0] rx_word;
	logic [PTR_W-1:0] rx_ptr_gray;
	logic cs_s1;
	logic cs_s2;
	logic cs_d;
	logic por_s1;
	logic por_s2;
	logic low_s1;
	logic low_s2;
	logic [PTR_W-1:0] ptr_s1;
	logic [PTR_W-1:0] ptr_s2;
	logic [PTR_W-1:0] prev_ptr_r;
	logic [PTR_W-1:0] ptr_bin;
	logic [PTR_W-1:0] ptr_diff;
	logic cs_rise;
	logic len_ok;
	logic take_r;
	ocfg_frame_s frame_r;
	logic clr;
	logic fail_trig;
	logic failsafe_r;
	logic wr_fault;
	logic wr_oc;
	logic wr_glob;
	logic wr_cal;
	logic [`OCFG_SEL_W-1:0] wr_sel;
	logic [`OCFG_DATA_W-1:0] wr_data;
	logic [NCH-1:0][`OCFG_FAULT_W-1:0] fault_r;
	logic [NCH-1:0][`OCFG_OC_W-1:0] oc_r;
	logic [`OCFG_DATA_W-1:0] glob_r;
	logic [`OCFG_DATA_W-1:0] cal_r;

	if (NCH != (1 << `OCFG_SEL_W)) begin : g_bad_nch
		$error("NCH must match the two channel select bits");
	end

	// ==========================================================
	// functions
	function automatic logic [PTR_W-1:0] gray2bin(
		input logic [PTR_W-1:0] g
	);
		logic [PTR_W-1:0] b;
		b = g;
		for (int i = PTR_W - 2; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction

	function automatic ocfg_chan_s dec_chan(
		input logic [`OCFG_FAULT_W-1:0] f,
		input logic [`OCFG_OC_W-1:0] o
	);
		ocfg_chan_s d;
		logic [1:0] cool;
		cool = o[`OCFG_OC_COOL_HI:`OCFG_OC_COOL_LO];
		d.retry_unlimited = f[`OCFG_FLT_RETRY_UNL];
		d.retry_disable = f[`OCFG_FLT_RETRY_DIS];
		d.supply_short_protect_disable = f[`OCFG_FLT_SHORT_DIS];
		if (f[`OCFG_FLT_ONOL_DIS]) begin
			d.on_openload_mode = ONOL_OFF;
		end else if (f[`OCFG_FLT_ONOL_LED]) begin
			d.on_openload_mode = ONOL_LED;
		end else begin
			d.on_openload_mode = ONOL_BULB;
		end
		d.off_openload_disable = f[`OCFG_FLT_OFFOL_DIS];
		d.sense_ratio_high = f[`OCFG_FLT_RATIO];
		unique case (cool)
			2'h1: begin
				d.cooling = COOL_SLOW;
			end
			2'h2: begin
				d.cooling = COOL_FAST;
			end
			// both 00 and 11 mean medium
			default: begin
				d.cooling = COOL_MEDIUM;
			end
		endcase
		d.inrush = ocfg_inrush_e'(o[`OCFG_OC_INR_HI:`OCFG_OC_INR_LO]);
		d.high_level_override = o[`OCFG_OC_HIGH_OVR];
		d.steady = ocfg_steady_e'(o[`OCFG_OC_STDY_HI:`OCFG_OC_STDY_LO]);
		d.overcurrent_mode_select = o[`OCFG_OC_MODE];
		return d;
	endfunction

	function automatic ocfg_glob_s dec_glob(
		input logic [`OCFG_DATA_W-1:0] g
	);
		ocfg_glob_s d;
		d.supply_fail_detect_en = g[`OCFG_GL_SUPPLY_EN];
		d.pwm_enable = g[`OCFG_GL_PWM_EN];
		if (!g[`OCFG_GL_PWM_EN]) begin
			d.pwm_clock = PCLK_NONE;
		end else if (g[`OCFG_GL_CLK_SEL]) begin
			d.pwm_clock = PCLK_INT;
		end else begin
			d.pwm_clock = PCLK_EXT;
		end
		// current copy wins over temperature
		if (g[`OCFG_GL_CUR_EN]) begin
			d.feedback_mode = FB_CURRENT;
		end else if (g[`OCFG_GL_TEMP_EN]) begin
			d.feedback_mode = FB_TEMP;
		end else begin
			d.feedback_mode = FB_TRISTATE;
		end
		d.feedback_channel = g[`OCFG_GL_COPY_HI:`OCFG_GL_COPY_LO];
		d.overvoltage_protect_disable = g[`OCFG_GL_OVERVOLTAGE_PROTECT_DISABLE];
		return d;
	endfunction

	// ==========================================================
	// link clock receiver
	ocfg_spi_rx #(
		.PTR_W(PTR_W)
	) u_rx (
		.spi_sclk(spi_sclk),
		.sys_rst(sys_rst),
		.spi_cs_n(spi_cs_n),
		.spi_si(spi_si),
		.word(rx_word),
		.bit_ptr_gray(rx_ptr_gray)
	);

	// ==========================================================
	// crossings into clk
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cs_s1 <= `OCFG_CS_IDLE;
			cs_s2 <= `OCFG_CS_IDLE;
			cs_d <= `OCFG_CS_IDLE;
		end else begin
			cs_s1 <= spi_cs_n;
			cs_s2 <= cs_s1;
			cs_d <= cs_s2;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ptr_s1 <= '0;
			ptr_s2 <= '0;
		end else begin
			ptr_s1 <= rx_ptr_gray;
			ptr_s2 <= ptr_s1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			por_s1 <= 1'b0;
			por_s2 <= 1'b0;
			low_s1 <= 1'b0;
			low_s2 <= 1'b0;
		end else begin
			por_s1 <= supply_por;
			por_s2 <= por_s1;
			low_s1 <= logic_supply_low;
			low_s2 <= low_s1;
		end
	end

	// ==========================================================
	// frame length check and latch
	assign cs_rise = cs_s2 & ~cs_d;
	assign ptr_bin = gray2bin(ptr_s2);
	assign ptr_diff = ptr_bin - prev_ptr_r;
	// nonzero and a whole number of words
	assign len_ok = (ptr_diff != '0) && (ptr_diff[`OCFG_CNT_W-1:0] == '0);

	// word is frozen while chip select is high, so it is sampled directly
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			prev_ptr_r <= '0;
			take_r <= 1'b0;
			frame_r <= '0;
		end else begin
			take_r <= cs_rise & len_ok;
			if (cs_rise) begin
				prev_ptr_r <= ptr_bin;
				frame_r <= ocfg_frame_s'(rx_word);
			end
		end
	end

	// ==========================================================
	// write decode
	assign wr_fault = take_r & (frame_r.addr == `OCFG_ADDR_FAULT);
	assign wr_oc = take_r & (frame_r.addr == `OCFG_ADDR_OC);
	assign wr_glob = take_r & (frame_r.addr == `OCFG_ADDR_GLOB);
	assign wr_cal = take_r & (frame_r.addr == `OCFG_ADDR_CAL);
	assign wr_sel = frame_r.sel;
	assign wr_data = frame_r.data;
	assign fail_trig = glob_r[`OCFG_GL_SUPPLY_EN] & low_s2;
	assign clr = sys_rst | por_s2 | fail_trig;

	// ==========================================================
	// configuration registers
	always_ff @(posedge clk) begin
		if (clr) begin
			fault_r <= {NCH{`OCFG_RST_FAULT}};
		end else if (wr_fault) begin
			fault_r[wr_sel] <= wr_data[`OCFG_FAULT_W-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (clr) begin
			oc_r <= {NCH{`OCFG_RST_OC}};
		end else if (wr_oc) begin
			oc_r[wr_sel] <= wr_data[`OCFG_OC_W-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (clr) begin
			glob_r <= `OCFG_RST_GLOB;
			cal_r <= `OCFG_RST_CAL;
		end else begin
			if (wr_glob) begin
				glob_r <= wr_data & `OCFG_GL_MASK;
			end
			if (wr_cal) begin
				cal_r <= wr_data;
			end
		end
	end

	// fail-safe holds until reset or power-on
	always_ff @(posedge clk) begin
		if (sys_rst | por_s2) begin
			failsafe_r <= 1'b0;
		end else if (fail_trig) begin
			failsafe_r <= 1'b1;
		end
	end

	// ==========================================================
	// outputs
	for (genvar g = 0; g < NCH; g++) begin : g_chan
		assign chan_cfg[g] = dec_chan(fault_r[g], oc_r[g]);
	end
	assign glob_cfg = dec_glob(glob_r);
	assign outputs_from_pwm = glob_r[`OCFG_GL_PWM_EN];
	assign failsafe = failsafe_r;
	assign osc_cal = cal_r;

	// ==========================================================
	// assertions
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	chk_sel_isolate: assert property (
		wr_fault && (wr_sel != 2'h0) && !clr |=> $stable(fault_r[0])
	) else $error("write to another channel changed channel 0");

	chk_fault_lands: assert property (
		wr_fault && !clr |=> fault_r[$past(wr_sel)] == $past(wr_data[`OCFG_FAULT_W-1:0])
	) else $error("fault config write did not land");

	chk_bad_len_drop: assert property (
		cs_rise && !len_ok |=> !take_r ##1 !take_r
	) else $error("frame of bad length was taken");

	chk_good_len_take: assert property (
		cs_rise && len_ok |=> take_r ##1 !take_r
	) else $error("valid frame not taken exactly once");

	chk_clear_cfg: assert property (
		por_s2 || fail_trig |=> (glob_r == '0) && (fault_r == '0) && (oc_r == '0) && (cal_r == '0)
	) else $error("configuration not cleared");

	chk_onol_off: assert property (
		fault_r[0][`OCFG_FLT_ONOL_DIS] |-> chan_cfg[0].on_openload_mode == ONOL_OFF
	) else $error("on open-load not disabled");

	chk_fb_current: assert property (
		glob_r[`OCFG_GL_CUR_EN] |-> glob_cfg.feedback_mode == FB_CURRENT
	) else $error("current feedback not selected");

	chk_pwm_clock: assert property (
		!glob_r[`OCFG_GL_PWM_EN] |-> glob_cfg.pwm_clock == PCLK_NONE
	) else $error("pwm clock chosen while module disabled");

	chk_unused_bit: assert property (
		wr_glob && !clr |=> !glob_r[`OCFG_GL_UNUSED]
	) else $error("unused global bit stored");

	chk_failsafe_set: assert property (
		fail_trig && !por_s2 |=> failsafe_r ##1 (failsafe_r || $past(por_s2))
	) else $error("fail-safe not held");

	chk_idle_hold: assert property (
		!take_r && !clr |=> $stable(oc_r) && $stable(glob_r)
	) else $error("registers changed without a frame");

	cov_fault_write: cover property (wr_fault && !clr);
	cov_oc_write: cover property (wr_oc && !clr);
	cov_bad_frame: cover property (cs_rise && !len_ok && (ptr_diff != '0));
	cov_failsafe: cover property (fail_trig);
endmodule

// ===== sim/ocfg_mcu_model.sv
// microcontroller side of the serial link, 125 ns bit period
module ocfg_mcu_model (
	output logic spi_sclk,
	output logic spi_cs_n,
	output logic spi_si
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		spi_sclk = 1'h0;
		spi_cs_n = 1'h1;
		spi_si = 1'h0;
	end
	// ==========================================
	// frame of n bits, msb first, clock still outside frames
	task automatic send(input int n, input logic [31:0] bits);
		#1.3;
		spi_cs_n = 1'h0;
		for (int i = n - 1; i >= 0; i--) begin
			spi_si = bits[i];
			#62.5 spi_sclk = 1'h1;
			#62.5 spi_sclk = 1'h0;
		end
		#62.5 spi_cs_n = 1'h1;
		// released line carries no valid data
		spi_si = ~spi_si;
		// cs_n stays high long enough for the clk domain to see it
		#100;
	endtask
endmodule

// ===== sim/testbench.sv
// self-checking bench for the output protection configuration bank
module testbench
	import ocfg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'h0;
	logic sys_rst;
	logic supply_por = 1'h0;
	logic logic_supply_low = 1'h0;
	wire logic spi_sclk;
	wire logic spi_cs_n;
	wire logic spi_si;
	ocfg_chan_s [3:0] chan_cfg;
	ocfg_glob_s glob_cfg;
	logic outputs_from_pwm;
	logic failsafe;
	logic [8:0] osc_cal;
	ocfg_chan_s [3:0] exp_ch;
	ocfg_glob_s exp_gl;
	logic [8:0] exp_cal;
	logic exp_fs;
	int err_count = 0;
	int comparisons = 0;
	ocfg_cool_e cool_t [4] = '{COOL_MEDIUM, COOL_SLOW, COOL_FAST, COOL_MEDIUM};
	ocfg_inrush_e inr_t [4] = '{INR_SLOW, INR_FAST, INR_MEDIUM, INR_VSLOW};
	ocfg_steady_e stdy_t [4] = '{STDY_TWO, STDY_THREE, STDY_FOUR, STDY_ONE};
	logic [8:0] glob_t [4] = '{9'h1ff, 9'h080, 9'h0e4, 9'h018};
	logic [8:0] flt_t [4] = '{9'h07f, 9'h002, 9'h005, 9'h1f0};

	ocfg_top #(.NCH(4), .PTR_W(8)) DUT (
		.clk(clk),
		.sys_rst(sys_rst),
		.spi_sclk(spi_sclk),
		.spi_cs_n(spi_cs_n),
		.spi_si(spi_si),
		.supply_por(supply_por),
		.logic_supply_low(logic_supply_low),
		.chan_cfg(chan_cfg),
		.glob_cfg(glob_cfg),
		.outputs_from_pwm(outputs_from_pwm),
		.failsafe(failsafe),
		.osc_cal(osc_cal)
	);
	ocfg_mcu_model u_mcu (
		.spi_sclk(spi_sclk),
		.spi_cs_n(spi_cs_n),
		.spi_si(spi_si)
	);

	initial begin
		forever #2 clk = ~clk;
	end

	// ==========================================
	// checking and expectations
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic chk_all();
		// look after the edge has settled, never in its own time step
		#1;
		for (int c = 0; c < 4; c++) begin
			check("chan_cfg", 32'(chan_cfg[c]), 32'(exp_ch[c]));
		end
		check("glob_cfg", 32'(glob_cfg), 32'(exp_gl));
		check("outputs_from_pwm", 32'(outputs_from_pwm), 32'(exp_gl.pwm_enable));
		check("osc_cal", 32'(osc_cal), 32'(exp_cal));
		check("failsafe", 32'(failsafe), 32'(exp_fs));
	endtask

	task automatic clr_exp();
		exp_ch = '0;
		exp_gl = '0;
		exp_cal = '0;
	endtask

	function automatic logic [15:0] fr(input logic [1:0] s, input logic [2:0] a, input logic [8:0] d);
		return {1'h0, s, a, 1'h0, d};
	endfunction

	task automatic exp_upd(input logic [1:0] s, input logic [2:0] a, input logic [8:0] d);
		case (a)
			3'h3: begin
				exp_ch[s].retry_unlimited = d[6];
				exp_ch[s].retry_disable = d[5];
				exp_ch[s].supply_short_protect_disable = d[4];
				exp_ch[s].on_openload_mode = d[3] ? ONOL_OFF : d[1] ? ONOL_LED : ONOL_BULB;
				exp_ch[s].off_openload_disable = d[2];
				exp_ch[s].sense_ratio_high = d[0];
			end
			3'h4: begin
				exp_ch[s].cooling = cool_t[d[7:6]];
				exp_ch[s].inrush = inr_t[d[5:4]];
				exp_ch[s].high_level_override = d[3];
				exp_ch[s].steady = stdy_t[d[2:1]];
				exp_ch[s].overcurrent_mode_select = d[0];
			end
			3'h5: begin
				exp_gl.supply_fail_detect_en = d[8];
				exp_gl.pwm_enable = d[7];
				exp_gl.pwm_clock = !d[7] ? PCLK_NONE : d[6] ? PCLK_INT : PCLK_EXT;
				exp_gl.feedback_mode = d[4] ? FB_CURRENT : d[5] ? FB_TEMP : FB_TRISTATE;
				exp_gl.feedback_channel = d[3:2];
				exp_gl.overvoltage_protect_disable = d[0];
			end
			3'h7: exp_cal = d;
			default: ;
		endcase
	endtask

	task automatic wr(input logic [1:0] s, input logic [2:0] a, input logic [8:0] d);
		u_mcu.send(16, {16'h0, fr(s, a, d)});
		repeat (2) @(posedge clk);
		exp_upd(s, a, d);
		chk_all();
	endtask

	// ==========================================
	// scenarios
	task automatic t_regs();
		chk_all();
		for (int k = 0; k < 4; k++) begin
			wr(2'(k), 3'h3, flt_t[k]);
			wr(2'(k), 3'h4, {1'h1, 2'(k), ~2'(k), k[0], 2'(k), k[1]});
			wr(2'(k), 3'h5, glob_t[k]);
		end
		wr(2'h1, 3'h7, 9'h15a);
	endtask

	task automatic t_refuse();
		u_mcu.send(15, {16'h0, fr(2'h0, 3'h3, 9'h000)});
		u_mcu.send(17, {15'h0, 1'h0, fr(2'h0, 3'h3, 9'h000)});
		wr(2'h0, 3'h6, 9'h1ff);
		wr(2'h0, 3'h1, 9'h1ff);
		u_mcu.send(32, {fr(2'h2, 3'h3, 9'h07f), fr(2'h3, 3'h4, 9'h0aa)});
		exp_upd(2'h3, 3'h4, 9'h0aa);
		repeat (2) @(posedge clk);
		chk_all();
		fork
			u_mcu.send(16, {16'h0, fr(2'h1, 3'h3, 9'h07f)});
			begin
				#1000;
				chk_all();
			end
		join
		exp_upd(2'h1, 3'h3, 9'h07f);
		repeat (2) @(posedge clk);
		chk_all();
	endtask

	task automatic t_supply();
		@(posedge clk);
		logic_supply_low <= 1'h1;
		repeat (6) @(posedge clk);
		chk_all();
		logic_supply_low <= 1'h0;
		repeat (4) @(posedge clk);
		wr(2'h0, 3'h5, 9'h100);
		@(posedge clk);
		logic_supply_low <= 1'h1;
		repeat (6) @(posedge clk);
		clr_exp();
		exp_fs = 1'h1;
		chk_all();
		logic_supply_low <= 1'h0;
		repeat (6) @(posedge clk);
		chk_all();
		supply_por <= 1'h1;
		repeat (6) @(posedge clk);
		supply_por <= 1'h0;
		exp_fs = 1'h0;
		repeat (4) @(posedge clk);
		chk_all();
		wr(2'h2, 3'h4, 9'h0ff);
		@(posedge clk);
		supply_por <= 1'h1;
		repeat (6) @(posedge clk);
		supply_por <= 1'h0;
		clr_exp();
		repeat (4) @(posedge clk);
		chk_all();
		wr(2'h3, 3'h3, 9'h07f);
		@(posedge clk);
		sys_rst <= 1'h1;
		repeat (4) @(posedge clk);
		sys_rst <= 1'h0;
		clr_exp();
		@(posedge clk);
		chk_all();
		wr(2'h0, 3'h7, 9'h0c3);
	endtask

	// ==========================================
	// run control
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	initial begin
		// a real edge at time zero, so the link side reset fires too
		sys_rst <= 1'h1;
		clr_exp();
		exp_fs = 1'h0;
		repeat (4) @(posedge clk);
		sys_rst <= 1'h0;
		repeat (2) @(posedge clk);
		t_regs();
		t_refuse();
		t_supply();
		test_done();
	end

	initial begin
		#300000;
		err_count++;
		test_done();
	end
endmodule
